// >>> inc/dotp_pkg.sv
// constants, types and register map of the digital output test and pulse generator
// assumes a 20 MHz system clock and a classic wishbone slave with 32-bit data
package dotp_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned CLK_MHZ           = 20;
  localparam int unsigned SLOT_US           = 10_000;
  localparam int unsigned SLOT_CYCLES       = SLOT_US * CLK_MHZ;
  localparam int unsigned LOW_MAX_US        = 5_000;
  localparam int unsigned LOW_MAX_CYCLES    = LOW_MAX_US * CLK_MHZ;
  localparam int unsigned COMPAT_LOW_US     = 40_000;
  localparam int unsigned COMPAT_LOW_CYCLES = COMPAT_LOW_US * CLK_MHZ;

  // rate limits
  localparam int unsigned MAX_SLOT_PULSES   = 100;
  localparam int unsigned PULSE_RATE_SCALE  = 100;

  // widths
  localparam int unsigned ADR_W  = 18;
  localparam int unsigned IDX_W  = 16;
  localparam int unsigned ACC_W  = 25;
  localparam int unsigned SDIV_W = 24;
  localparam int unsigned LOW_W  = 20;
  localparam int unsigned AMT_W  = 16;
  localparam int unsigned LIM_W  = 8;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SW0_TEST_EN  = 16'h6D18;
  localparam logic [IDX_W-1:0] IDX_SW0_TEST_LVL = 16'h6D1A;
  localparam logic [IDX_W-1:0] IDX_SW1_TEST_EN  = 16'h6E18;
  localparam logic [IDX_W-1:0] IDX_SW1_TEST_LVL = 16'h6E1A;
  localparam logic [IDX_W-1:0] IDX_P0_BASE      = 16'h6D00;
  localparam logic [IDX_W-1:0] IDX_P1_BASE      = 16'h6E00;
  localparam logic [IDX_W-1:0] OFS_P_TEST_EN    = 16'h0002;
  localparam logic [IDX_W-1:0] OFS_P_AMOUNT     = 16'h0004;
  localparam logic [IDX_W-1:0] OFS_P_MODE       = 16'h0006;
  localparam logic [IDX_W-1:0] OFS_P_LIMIT      = 16'h0008;
  localparam logic [IDX_W-1:0] OFS_P_COUNT      = 16'h000A;
  localparam logic [IDX_W-1:0] IDX_SLOT_DIV     = 16'h6F00;
  localparam logic [IDX_W-1:0] IDX_STATUS       = 16'h6F02;

  // pulse output modes
  typedef enum logic [2:0] {
    MODE_OFF         = 3'h0,
    MODE_PULSE_FWD   = 3'h1,
    MODE_PULSE_REV   = 3'h2,
    MODE_PULSE_90    = 3'h3,
    MODE_FREQ_FAST   = 3'h4,
    MODE_FREQ_COMPAT = 3'h5
  } dotp_mode_t;

  // wishbone slave answer state
  typedef enum logic {
    WB_IDLE = 1'b0,
    WB_ACK  = 1'b1
  } dotp_wb_state_t;

  // wishbone request from the master
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } dotp_wb_req_t;

  // software settings of one versatile output
  typedef struct packed {
    logic [2:0]       mode;
    logic             test_on;
    logic [AMT_W-1:0] amount;
    logic [LIM_W-1:0] limit;
  } dotp_vchan_t;

  localparam logic [LIM_W-1:0] LIMIT_RST = 8'h64;
  localparam dotp_vchan_t VCH_RST = '{mode: 3'h0, test_on: 1'b0, amount: 16'h0000,
                                      limit: LIMIT_RST};

endpackage

// >>> rtl/dotp_top.sv
// switched output test forcing and versatile pulse / frequency generation
// assumes synchronous inputs, one 20 MHz clock and a classic wishbone master
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// [R1] register writes reach outputs without restart
// [R2] reset returns every test setting to inactive
// [R3] test enable drives switched output to level
// [R4] level change flips the forced output
// [R5] clearing enable restores normal output function
// [R6] mode register selects pulse or frequency meaning
// [R7] pulse test emits amount pulses per slot
// [R8] pulse rate equals amount times hundred
// [R9] frequency test uses amount as hertz
// [R10] low phase capped at five milliseconds
// [R11] compatibility mode caps low at forty ms
// [R12] never more than hundred pulses per slot
// [R13] per channel slot limit caps pulse count
// [R14] forward pulses suppressed during reverse flow
// [R15] reverse pulses suppressed during positive flow
// [R16] reversal moves second output to 270 degrees
// [R17] receiver uses frequency for rate, pulses for totals
// [R18] programmable slot divider, pulses spread evenly
module dotp_top
  import dotp_pkg::*;
#(
  parameter int unsigned SLOT_DIV_RST   = SLOT_CYCLES,
  parameter int unsigned LOW_MAX_CYC    = LOW_MAX_CYCLES,
  parameter int unsigned COMPAT_LOW_CYC = COMPAT_LOW_CYCLES
) (
  // system
  input  wire logic         clk_i,
  input  wire dotp_wb_req_t wb_i,
  input  wire logic         rst_i,
  // wishbone answer
  output logic              wb_ack_o,
  output logic [31:0]       wb_dat_o,
  // normal function and flow direction
  input  wire logic [1:0]   sw_normal_i,
  input  wire logic         flow_reverse_i,
  // physical outputs
  output logic [1:0]        sw_out_o,
  output logic [1:0]        pls_out_o
);

  // refuse slot and compatibility low settings the counters cannot hold
  if (SLOT_DIV_RST < 4 || SLOT_DIV_RST >= (1 << SDIV_W)) begin : g_chk_slot
    $error("slot divider reset out of range");
  end
  if (LOW_MAX_CYC < 1 || COMPAT_LOW_CYC >= (1 << LOW_W)) begin : g_chk_low
    $error("low phase limit out of range");
  end

  // smaller of a value and a limit
  function automatic logic [AMT_W-1:0] clamp(input logic [AMT_W-1:0] v,
                                             input logic [AMT_W-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // byte lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // base index of a versatile channel
  function automatic logic [IDX_W-1:0] pbase(input int c);
    return (c == 0) ? IDX_P0_BASE : IDX_P1_BASE;
  endfunction

  // state
  dotp_wb_state_t    wb_state, next_wb_state;
  logic [31:0]       rd_data, next_rd_data;
  logic [1:0]        sw_en, next_sw_en;
  logic [1:0]        sw_lvl, next_sw_lvl;
  dotp_vchan_t       vch [2];
  dotp_vchan_t       next_vch [2];
  logic [SDIV_W-1:0] slot_div, next_slot_div;
  logic [SDIV_W-1:0] slot_cnt, next_slot_cnt;
  logic [ACC_W-1:0]  acc [2];
  logic [ACC_W-1:0]  next_acc [2];
  logic [LOW_W-1:0]  low_cnt [2];
  logic [LOW_W-1:0]  next_low_cnt [2];
  logic [31:0]       pcount [2];
  logic [31:0]       next_pcount [2];
  logic [1:0]        next_sw_out, next_pls_out;

  // decode
  logic [IDX_W-1:0]  idx;
  logic              req, wr;
  logic [1:0]        start_wr;
  logic              slot_tick;

  // per channel datapath terms
  logic [1:0]        is_pulse, run, wrap, low_ph;
  logic [ACC_W-1:0]  modulus [2];
  logic [ACC_W-1:0]  inc [2];
  logic [LOW_W-1:0]  low_max [2];

  // bus decode, writes land at the edge that carries ack
  assign idx = wb_i.adr[ADR_W-1:2];
  assign req = wb_i.cyc & wb_i.stb;
  assign wr  = req & wb_i.we & wb_ack_o;
  // only a nonzero test enable write starts a channel; a stop keeps the count
  assign start_wr[0] = wr && (idx == (pbase(0) | OFS_P_TEST_EN))
                    && (merge(32'h0000_0000, wb_i.dat, wb_i.sel) != 32'h0000_0000); // [R1]
  assign start_wr[1] = wr && (idx == (pbase(1) | OFS_P_TEST_EN))
                    && (merge(32'h0000_0000, wb_i.dat, wb_i.sel) != 32'h0000_0000); // [R1]
  assign slot_tick = (slot_cnt >= slot_div - 1'b1);

  // wishbone answer and read mux
  always_comb begin
    next_wb_state = WB_IDLE;
    next_rd_data  = rd_data;
    if (wb_state == WB_IDLE && req) begin
      next_wb_state = WB_ACK;
      next_rd_data  = 32'h0000_0000;
      case (idx)
        IDX_SW0_TEST_EN:  next_rd_data = {31'h0, sw_en[0]};
        IDX_SW0_TEST_LVL: next_rd_data = {31'h0, sw_lvl[0]};
        IDX_SW1_TEST_EN:  next_rd_data = {31'h0, sw_en[1]};
        IDX_SW1_TEST_LVL: next_rd_data = {31'h0, sw_lvl[1]};
        IDX_SLOT_DIV:     next_rd_data = {8'h00, slot_div};
        IDX_STATUS:       next_rd_data = {27'h0, flow_reverse_i, pls_out_o, sw_out_o};
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (idx == (pbase(c) | OFS_P_TEST_EN)) next_rd_data = {31'h0, vch[c].test_on};
            if (idx == (pbase(c) | OFS_P_AMOUNT)) next_rd_data = {16'h0, vch[c].amount};
            if (idx == (pbase(c) | OFS_P_MODE)) next_rd_data = {29'h0, vch[c].mode};
            if (idx == (pbase(c) | OFS_P_LIMIT)) next_rd_data = {24'h0, vch[c].limit};
            if (idx == (pbase(c) | OFS_P_COUNT)) next_rd_data = pcount[c];
          end
        end
      endcase
    end
  end

  // software registers
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    next_sw_en    = sw_en;
    next_sw_lvl   = sw_lvl;
    next_slot_div = slot_div;
    for (int c = 0; c < 2; c++) begin
      next_vch[c] = vch[c];
    end
    if (wr) begin
      case (idx)
        IDX_SW0_TEST_EN: begin
          m = merge({31'h0, sw_en[0]}, wb_i.dat, wb_i.sel);
          next_sw_en[0] = m[0]; // [R1] [R3] [R5]
        end
        IDX_SW0_TEST_LVL: begin
          m = merge({31'h0, sw_lvl[0]}, wb_i.dat, wb_i.sel);
          next_sw_lvl[0] = m[0]; // [R4]
        end
        IDX_SW1_TEST_EN: begin
          m = merge({31'h0, sw_en[1]}, wb_i.dat, wb_i.sel);
          next_sw_en[1] = m[0]; // [R1] [R3] [R5]
        end
        IDX_SW1_TEST_LVL: begin
          m = merge({31'h0, sw_lvl[1]}, wb_i.dat, wb_i.sel);
          next_sw_lvl[1] = m[0]; // [R4]
        end
        IDX_SLOT_DIV: begin
          m = merge({8'h00, slot_div}, wb_i.dat, wb_i.sel);
          next_slot_div = (m[SDIV_W-1:0] < 24'h000004) ? 24'h000004 : m[SDIV_W-1:0]; // [R18]
        end
        default: begin
          for (int c = 0; c < 2; c++) begin
            if (idx == (pbase(c) | OFS_P_TEST_EN)) begin // [R1] zero stops, nonzero starts
              m = merge(32'h0000_0000, wb_i.dat, wb_i.sel);
              next_vch[c].test_on = (m != 32'h0000_0000);
            end
            if (idx == (pbase(c) | OFS_P_AMOUNT)) begin
              m = merge({16'h0, vch[c].amount}, wb_i.dat, wb_i.sel);
              next_vch[c].amount = m[AMT_W-1:0];
            end
            if (idx == (pbase(c) | OFS_P_MODE)) begin
              m = merge({29'h0, vch[c].mode}, wb_i.dat, wb_i.sel);
              next_vch[c].mode = m[2:0]; // [R6]
            end
            if (idx == (pbase(c) | OFS_P_LIMIT)) begin
              m = merge({24'h0, vch[c].limit}, wb_i.dat, wb_i.sel);
              next_vch[c].limit = m[LIM_W-1:0]; // [R13]
            end
          end
        end
      endcase
    end
  end

  // per channel rate, gating and phase terms
  always_comb begin
    logic [ACC_W:0]   sum;
    logic [AMT_W-1:0] lim;
    logic             gated;
    sum   = '0;
    lim   = '0;
    gated = 1'b0;
    for (int c = 0; c < 2; c++) begin
      is_pulse[c] = vch[c].mode == MODE_PULSE_FWD || vch[c].mode == MODE_PULSE_REV
                 || vch[c].mode == MODE_PULSE_90; // [R6]
      lim = clamp({8'h00, vch[c].limit}, AMT_W'(MAX_SLOT_PULSES)); // [R12] [R13]
      gated = (vch[c].mode == MODE_PULSE_FWD && flow_reverse_i)    // [R14]
           || (vch[c].mode == MODE_PULSE_REV && !flow_reverse_i);  // [R15]
      run[c] = vch[c].test_on && !gated
            && (is_pulse[c] || vch[c].mode == MODE_FREQ_FAST
                || vch[c].mode == MODE_FREQ_COMPAT);
      // pulse mode divides the slot, frequency mode divides one second
      modulus[c] = is_pulse[c] ? {1'b0, slot_div} : ACC_W'(CLK_HZ); // [R7] [R8] [R9]
      inc[c] = is_pulse[c] ? {9'h000, clamp(vch[c].amount, lim)}
             : {9'h000, clamp(vch[c].amount, AMT_W'(lim * PULSE_RATE_SCALE))}; // [R9] [R12]
      low_max[c] = (vch[c].mode == MODE_FREQ_COMPAT) ? LOW_W'(COMPAT_LOW_CYC) // [R11]
                 : LOW_W'(LOW_MAX_CYC);                                       // [R10]
      sum = {1'b0, acc[c]} + {1'b0, inc[c]};
      wrap[c] = run[c] && (sum >= {1'b0, modulus[c]}); // [R18]
      low_ph[c] = run[c] && (acc[c] >= (modulus[c] >> 1)) && (low_cnt[c] < low_max[c]);
    end
  end

  // accumulators, low timers, counters and output levels
  always_comb begin
    logic [ACC_W:0]   sum;
    logic [ACC_W-1:0] quarter;
    logic [ACC_W-1:0] half;
    logic [ACC_W-1:0] q;
    sum     = '0;
    quarter = modulus[0] >> 2;
    half    = modulus[0] >> 1;
    q       = acc[0];
    // a starting test opens a fresh slot, so its first slot is whole
    next_slot_cnt = (slot_tick || start_wr != 2'b00) ? '0 : slot_cnt + 1'b1; // [R7] [R18]
    for (int c = 0; c < 2; c++) begin
      sum = {1'b0, acc[c]} + {1'b0, inc[c]};
      next_acc[c] = wrap[c] ? ACC_W'(sum - {1'b0, modulus[c]}) : sum[ACC_W-1:0];
      if (!run[c] || start_wr[c]) begin
        next_acc[c] = '0;
      end else if (is_pulse[c] && slot_tick) begin
        next_acc[c] = '0; // [R7] every slot starts clean
      end
      if (!run[c] || start_wr[c] || wrap[c]) begin
        next_low_cnt[c] = '0;
      end else if (low_ph[c]) begin
        next_low_cnt[c] = low_cnt[c] + 1'b1; // [R10] [R11]
      end else begin
        next_low_cnt[c] = low_cnt[c];
      end
      if (start_wr[c]) begin
        next_pcount[c] = 32'h0000_0000;
      end else if (wrap[c]) begin
        next_pcount[c] = pcount[c] + 1'b1;
      end else begin
        next_pcount[c] = pcount[c];
      end
      next_pls_out[c] = !low_ph[c]; // idle high, pulse is a low phase
      next_sw_out[c]  = sw_en[c] ? sw_lvl[c] : sw_normal_i[c]; // [R3] [R4] [R5]
    end
    // first output falls at half a period; the second falls a quarter later,
    // or three quarters later while flow reverses
    // the wrapped part of the forward window waits for the first wrap
    if (vch[0].mode == MODE_PULSE_90) begin
      if (!flow_reverse_i) begin
        next_pls_out[1] = !(run[0] && (q >= quarter + half
                            || (q < quarter && pcount[0] != 32'h0000_0000))); // [R16]
      end else begin
        next_pls_out[1] = !(run[0] && q >= quarter && q < quarter + half); // [R16]
      end
    end
  end

  // register stage, reset clears every test setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state  <= WB_IDLE;
      wb_ack_o  <= 1'b0;
      rd_data   <= 32'h0000_0000;
      sw_en     <= 2'h0; // [R2]
      sw_lvl    <= 2'h0; // [R2]
      slot_div  <= SDIV_W'(SLOT_DIV_RST);
      slot_cnt  <= '0;
      sw_out_o  <= 2'h0;
      pls_out_o <= 2'h3;
      for (int c = 0; c < 2; c++) begin
        vch[c]     <= VCH_RST; // [R2]
        acc[c]     <= '0;
        low_cnt[c] <= '0;
        pcount[c]  <= 32'h0000_0000;
      end
    end else begin
      wb_state  <= next_wb_state;
      wb_ack_o  <= (next_wb_state == WB_ACK);
      rd_data   <= next_rd_data;
      sw_en     <= next_sw_en;
      sw_lvl    <= next_sw_lvl;
      slot_div  <= next_slot_div;
      slot_cnt  <= next_slot_cnt;
      sw_out_o  <= next_sw_out;
      pls_out_o <= next_pls_out;
      for (int c = 0; c < 2; c++) begin
        vch[c]     <= next_vch[c];
        acc[c]     <= next_acc[c];
        low_cnt[c] <= next_low_cnt[c];
        pcount[c]  <= next_pcount[c];
      end
    end
  end

  assign wb_dat_o = rd_data;

  // checking helpers: pulses per slot and length of low phases on output 0
  logic [7:0]  slot_wraps0;
  logic        steady0;
  logic [LOW_W:0] low_run0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_wraps0 <= 8'h00;
      steady0     <= 1'b0;
      low_run0    <= '0;
    end else begin
      slot_wraps0 <= slot_tick ? 8'h00 : slot_wraps0 + {7'h00, wrap[0]};
      if (slot_tick) begin
        steady0 <= run[0] && is_pulse[0];
      end else if (!run[0] || start_wr != 2'b00 || slot_div != next_slot_div
                   || vch[0] != next_vch[0]) begin
        steady0 <= 1'b0;
      end
      low_run0 <= pls_out_o[0] ? '0 : low_run0 + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_clears: assert property ($fell(rst_i) |-> sw_en == 2'h0 && sw_lvl == 2'h0 // [R2]
      && !vch[0].test_on && !vch[1].test_on) else $error("test settings survived reset");
  a_write_immediate: assert property (wr && idx == IDX_SW0_TEST_EN && wb_i.sel[0] // [R1]
      |=> sw_en[0] == $past(wb_i.dat[0])) else $error("test enable write not applied");
  a_sw_forced: assert property (sw_en[0] |=> sw_out_o[0] == $past(sw_lvl[0])) // [R3]
    else $error("forced output does not follow test level");
  a_sw_level_on: assert property ($rose(sw_lvl[1]) && sw_en[1] |=> sw_out_o[1]) // [R4]
    else $error("level rise did not switch output on");
  a_sw_released: assert property (!sw_en[1] |=> sw_out_o[1] == $past(sw_normal_i[1])) // [R5]
    else $error("released output ignores normal function");
  a_slot_exact: assert property (slot_tick && steady0 && run[0] // [R7]
      |-> slot_wraps0 + {7'h00, wrap[0]} == inc[0][7:0]) else $error("wrong pulses per slot");
  a_slot_cap: assert property (slot_wraps0 <= 8'(MAX_SLOT_PULSES)) // [R12]
    else $error("more than the allowed pulses in a slot");
  a_low_limit: assert property (vch[0].mode != MODE_FREQ_COMPAT && $stable(vch[0].mode) // [R10]
      |-> low_run0 <= (LOW_W+1)'(LOW_MAX_CYC) + 1'b1) else $error("low phase too long");
  a_compat_low: assert property (low_run0 <= (LOW_W+1)'(COMPAT_LOW_CYC) + 1'b1) // [R11]
    else $error("compatibility low phase too long");
  a_fwd_gate: assert property (vch[0].mode == MODE_PULSE_FWD && flow_reverse_i // [R14]
      ##1 flow_reverse_i |-> pls_out_o[0]) else $error("forward pulse during reverse flow");
  a_rev_gate: assert property (vch[1].mode == MODE_PULSE_REV && !flow_reverse_i // [R15]
      && vch[0].mode != MODE_PULSE_90 |=> pls_out_o[1])
    else $error("reverse pulse during forward flow");

  c_sw_test: cover property (sw_en[0] ##1 $fell(sw_out_o[0]));
  c_pulse_wrap: cover property (is_pulse[0] && wrap[0] ##1 !pls_out_o[0] [*2]);
  c_freq_run: cover property (vch[1].mode == MODE_FREQ_FAST && wrap[1]);
  c_quad_rev: cover property (vch[0].mode == MODE_PULSE_90 && flow_reverse_i
      && $fell(pls_out_o[1]));

endmodule

// >>> tb/dotp_pulse_counter.sv
// pulse counting receiver on the two versatile outputs
// assumes outputs idle high, each pulse shown as one low phase
`timescale 1ns/1ns
module dotp_pulse_counter (
  // clock and clear
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  // versatile outputs seen at the receiver
  input  wire logic [1:0] pls_i,
  // totals, last low width of output one, fall to fall lag
  output int              cnt0_o,
  output int              cnt1_o,
  output int              low0_o,
  output int              lag_o
);
  logic [1:0] prev;
  int         run0;
  int         since0;

  // totals from counted falling edges, never turned into a rate
  always @(posedge clk_i) begin
    prev <= pls_i;
    if (clr_i) begin
      cnt0_o <= 0;
      cnt1_o <= 0;
    end else begin
      if (prev[0] && !pls_i[0]) cnt0_o <= cnt0_o + 1;
      if (prev[1] && !pls_i[1]) cnt1_o <= cnt1_o + 1;
    end
  end

  // width of each low phase of output one and delay from output one to output two
  always @(posedge clk_i) begin
    run0 <= pls_i[0] ? 0 : run0 + 1;
    if (pls_i[0] && run0 != 0) low0_o <= run0;
    since0 <= (prev[0] && !pls_i[0]) ? 0 : since0 + 1;
    if (prev[1] && !pls_i[1]) lag_o <= since0;
  end
endmodule

// >>> tb/tb_digital_output_test_pulse_gen.sv
// self-checking bench for the output test and pulse generator
// assumes short time parameters and the pulse counting receiver model
`timescale 1ns/1ns
module tb_digital_output_test_pulse_gen
  import dotp_pkg::*;
;
  localparam int SLOT = 40;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  dotp_wb_req_t wb_r = '0;
  logic         wb_ack_o;
  logic [31:0]  wb_dat_o;
  logic [1:0]   sw_normal_i = 2'h0;
  logic         flow_reverse_i = 1'b0;
  logic [1:0]   sw_out_o;
  logic [1:0]   pls_out_o;
  logic         clr = 1'b1;
  logic [32:0]  exp_q[$];
  logic [32:0]  e;
  int           cnt0, cnt1, low0, lag;
  int           failures = 0;
  int           comparisons = 0;
  int           seed = 76910;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  dotp_top #(.SLOT_DIV_RST(SLOT), .LOW_MAX_CYC(10), .COMPAT_LOW_CYC(30)) uut (
    .clk_i(clk_i), .wb_i(wb_r), .rst_i(rst_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .sw_normal_i(sw_normal_i), .flow_reverse_i(flow_reverse_i), .sw_out_o(sw_out_o),
    .pls_out_o(pls_out_o));

  dotp_pulse_counter rx (.clk_i(clk_i), .clr_i(clr), .pls_i(pls_out_o), .cnt0_o(cnt0),
    .cnt1_o(cnt1), .low0_o(low0), .lag_o(lag));

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // design value against expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // receiver measurement against a window
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH t=%0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // one classic bus cycle, expectation noted before the request
  task automatic wb(input logic we, input logic [IDX_W-1:0] idx, input logic [31:0] d,
                    input logic chk_on, input logic [31:0] exp);
    int n;
    @(posedge clk_i);
    exp_q.push_back({chk_on, exp});
    wb_r <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {idx, 2'b00}, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    wb_r <= '0;
    if (n >= 20 && wb_ack_o !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t bus answer missing", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    wb(1'b1, idx, d, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0, 1'b1, exp);
  endtask

  // forced output shows one edge after the write lands
  task automatic sw_chk(input logic [1:0] exp);
    repeat (2) @(posedge clk_i);
    chk({30'h0, sw_out_o}, {30'h0, exp}, "switched out");
  endtask

  // set up one versatile channel, run it, stop at a quiet point
  task automatic run(input logic [IDX_W-1:0] base, input int mode, input int amt,
                     input int lim, input int div, input int cyc, input int exp,
                     input logic reg_chk);
    wr(IDX_SLOT_DIV, 32'(div));
    wr(base + OFS_P_MODE, 32'(mode));
    wr(base + OFS_P_LIMIT, 32'(lim));
    wr(base + OFS_P_AMOUNT, 32'(amt));
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wr(base + OFS_P_TEST_EN, 32'h1);
    repeat (cyc) @(posedge clk_i);
    wr(base + OFS_P_TEST_EN, 32'h0);
    if (reg_chk) rd(base + OFS_P_COUNT, 32'(exp));
    chk_rng(base == IDX_P1_BASE ? cnt1 : cnt0, exp, exp, "pulse total");
    $display("test mode %0d amount %0d done", mode, amt);
  endtask

  // compare read data against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) chk(wb_dat_o, e[31:0], "read data");
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    clr <= 1'b0;
    rd(IDX_SW0_TEST_EN, 32'h0);
    rd(IDX_SW1_TEST_LVL, 32'h0);
    rd(IDX_P1_BASE + OFS_P_LIMIT, 32'h64);
    rd(IDX_SLOT_DIV, 32'(SLOT));
    wr(16'h0100, 32'h5A5A5A5A);
    rd(16'h0100, 32'h0);
    wr(IDX_P0_BASE + OFS_P_COUNT, 32'h55);
    rd(IDX_P0_BASE + OFS_P_COUNT, 32'h0);
    $display("test reset values done");
    sw_normal_i <= 2'($random(seed));
    wr(IDX_SW0_TEST_EN, 32'h1);
    sw_chk({sw_normal_i[1], 1'b0});
    wr(IDX_SW0_TEST_LVL, 32'h1);
    sw_chk({sw_normal_i[1], 1'b1});
    wr(IDX_SW1_TEST_LVL, 32'h1);
    wr(IDX_SW1_TEST_EN, 32'h1);
    sw_chk(2'b11);
    wr(IDX_SW0_TEST_LVL, 32'h0);
    sw_chk(2'b10);
    wr(IDX_SW1_TEST_LVL, 32'h0);
    sw_chk(2'b00);
    wr(IDX_SW1_TEST_LVL, 32'h1);
    sw_chk(2'b10);
    rd(IDX_SW1_TEST_EN, 32'h1);
    wr(IDX_SW0_TEST_EN, 32'h0);
    wr(IDX_SW1_TEST_EN, 32'h0);
    sw_chk(sw_normal_i);
    $display("test switched outputs done");
    run(IDX_P0_BASE, 1, 10, 100, 400, 1210, 30, 1'b1);
    chk_rng(low0, 9, 11, "pulse low");
    flow_reverse_i <= 1'b1;
    run(IDX_P0_BASE, 1, 10, 100, 400, 1210, 0, 1'b0);
    run(IDX_P1_BASE, 2, 10, 100, 400, 1210, 30, 1'b1);
    flow_reverse_i <= 1'b0;
    run(IDX_P1_BASE, 2, 10, 100, 400, 1210, 0, 1'b0);
    for (int m = 0; m < 3; m++) begin
      run(IDX_P0_BASE, m == 0 ? 0 : m + 5, 10, 100, 400, 410, 0, 1'b0);
    end
    run(IDX_P1_BASE, 1, 50, 20, 400, 1205, 60, 1'b1);
    run(IDX_P0_BASE, 1, 150, 200, 2000, 4005, 200, 1'b1);
    run(IDX_P0_BASE, 4, 5000, 100, 400, 21000, 5, 1'b1);
    chk_rng(low0, 9, 11, "fast low");
    run(IDX_P0_BASE, 5, 20000, 100, 400, 8500, 4, 1'b1);
    chk_rng(low0, 29, 31, "compat low");
    run(IDX_P0_BASE, 3, 10, 100, 400, 810, 20, 1'b0);
    chk_rng(lag, 7, 12, "lag forward");
    flow_reverse_i <= 1'b1;
    run(IDX_P0_BASE, 3, 10, 100, 400, 810, 20, 1'b0);
    chk_rng(lag, 27, 32, "lag reverse");
    flow_reverse_i <= 1'b0;
    wr(IDX_SW0_TEST_LVL, 32'h1);
    wr(IDX_SW0_TEST_EN, 32'h1);
    wr(IDX_P0_BASE + OFS_P_MODE, 32'h1);
    wr(IDX_P0_BASE + OFS_P_AMOUNT, 32'hA);
    wr(IDX_P0_BASE + OFS_P_TEST_EN, 32'h1);
    repeat (15) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    sw_chk(sw_normal_i);
    chk({30'h0, pls_out_o}, 32'h3, "idle pulse out");
    rd(IDX_SW0_TEST_LVL, 32'h0);
    rd(IDX_P0_BASE + OFS_P_TEST_EN, 32'h0);
    rd(IDX_P0_BASE + OFS_P_MODE, 32'h0);
    rd(IDX_SLOT_DIV, 32'(SLOT));
    $display("test mid-run reset done");
    final_report();
  end
endmodule
